// ### design/amer_core.sv
// Error reporting core of an analog expansion module: self-test, status
// indicator, output zeroing, range flags, configuration check and error word.
// Assumes samples and test results come from logic on clk; hw_fault_pin is async.
//
// Added by the designer: the Avalon-MM register port and the address map.
module amer_core
  import amer_pkg::*;
#(
  parameter int unsigned NCH = AMER_NCH,
  parameter int unsigned ST_STEPS = AMER_ST_STEPS,
  parameter int unsigned ST_SETTLE = AMER_ST_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [NCH-1:0][15:0] samples_i,
  input wire logic [NCH-1:0] sample_valid_i,
  input wire logic test_ok_i,
  output logic [7:0] test_sel_o,
  input wire logic hw_fault_pin,
  output logic [NCH-1:0][15:0] dac_o,
  output logic [NCH-1:0] over_o,
  output logic [NCH-1:0] under_o,
  output logic [15:0] err_word_o,
  output logic critical_o,
  output logic led_o,
  output logic irq
);
  localparam logic [31:0] CFG_USED = 32'((64'h1 << (2 * NCH)) - 64'h1);

  logic ack_q;
  logic [31:0] rdata_q;
  logic fault_s1_q, fault_s2_q, fault_s3_q, fault_f_q;
  logic st_done, st_pass, st_done_q;
  logic hw_fault_q;
  logic hw_active;
  logic [31:0] cfg_q;
  logic cfg_err_q;
  logic [8:0] cfg_code_q;
  amer_err_t err_q;
  amer_err_t err_d;
  logic led_q;
  logic [AMER_NIRQ-1:0] irq_st_q, irq_msk_q, irq_set, irq_clr;
  amer_image_t [NCH-1:0] image_q;
  logic [NCH-1:0][15:0] dac_q;
  logic [NCH-1:0][15:0] dac_out_q;
  logic [NCH-1:0] over_now, under_now;

  // Bus handshake: one wait cycle, the request is taken on the second edge
  logic req, bus_take, wr_en;
  assign req = read | write;
  assign waitrequest = req & ~ack_q;
  assign bus_take = req & ack_q;
  assign wr_en = write & ack_q;

  // Address decode
  logic [2:0] ch_idx;
  logic ch_ok;
  logic sel_err, sel_stat, sel_cfg, sel_ist, sel_imsk, sel_img, sel_dac;
  assign ch_idx = address[4:2];
  assign ch_ok = (32'(ch_idx) < NCH);
  assign sel_err = (address[7:2] == AMER_OFS_ERR[7:2]);
  assign sel_stat = (address[7:2] == AMER_OFS_STAT[7:2]);
  assign sel_cfg = (address[7:2] == AMER_OFS_CFG[7:2]);
  assign sel_ist = (address[7:2] == AMER_OFS_IRQ_ST[7:2]);
  assign sel_imsk = (address[7:2] == AMER_OFS_IRQ_MSK[7:2]);
  assign sel_img = (address[7:5] == AMER_OFS_IMG[7:5]) & ch_ok;
  assign sel_dac = (address[7:5] == AMER_OFS_DAC[7:5]) & ch_ok;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Fault pin: three stages, the filtered level moves when stages two and three agree
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      fault_s1_q <= 1'b0;
      fault_s2_q <= 1'b0;
      fault_s3_q <= 1'b0;
      fault_f_q <= 1'b0;
    end else begin
      fault_s1_q <= hw_fault_pin;
      fault_s2_q <= fault_s1_q;
      fault_s3_q <= fault_s2_q;
      if (fault_s2_q == fault_s3_q) begin
        fault_f_q <= fault_s3_q;
      end
    end
  end

  // Power-up diagnostics must finish before the outputs and indicator go live
  amer_selftest #(
    .STEPS(ST_STEPS),
    .SETTLE(ST_SETTLE)
  ) u_selftest (
    .clk(clk),
    .resetn(resetn),
    .test_ok(test_ok_i),
    .test_sel(test_sel_o),
    .done(st_done),
    .pass(st_pass)
  );

  // Hardware faults latch until power is cycled; a glitchy pin must not clear them
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      hw_fault_q <= 1'b0;
      st_done_q <= 1'b0;
    end else begin
      st_done_q <= st_done;
      if ((st_done && !st_pass) || fault_f_q) begin
        hw_fault_q <= 1'b1;
      end
    end
  end
  // A failed test counts from the cycle it ends, so no clean word or live output slips out
  assign hw_active = hw_fault_q | ~st_pass;

  // Configuration check on a candidate built from the byte lanes
  logic cfg_wr;
  logic [31:0] cfg_cand;
  logic cfg_ok;
  logic [8:0] bad_code;
  assign cfg_wr = wr_en & sel_cfg;
  assign cfg_cand = amer_merge(cfg_q, writedata, byteenable);
  // Reserved bits give the general code only when no range is bad; a bad range names its channel
  always_comb begin
    cfg_ok = ((cfg_cand & ~CFG_USED) == 32'h0000_0000);
    bad_code = AMER_EXT_GENERAL;
    for (int c = NCH - 1; c >= 0; c--) begin
      if (cfg_cand[2*c +: 2] > AMER_RANGE_MAX) begin
        cfg_ok = 1'b0;
        bad_code = 9'(c + 1);
      end
    end
  end

  // Rejected writes keep the last accepted setup and raise a non-critical error
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cfg_q <= AMER_CFG_RST;
      cfg_err_q <= 1'b0;
      cfg_code_q <= AMER_EXT_GENERAL;
    end else if (cfg_wr) begin
      if (cfg_ok) begin
        cfg_q <= cfg_cand;
        cfg_err_q <= 1'b0;
        cfg_code_q <= AMER_EXT_GENERAL;
      end else begin
        cfg_err_q <= 1'b1;
        cfg_code_q <= bad_code;
      end
    end
  end

  // Error word: hardware outranks configuration; power-up shows the hardware class with the power-up code
  always_comb begin
    err_d.dont_care = 4'h0;
    if (hw_active) begin
      err_d.cls = AMER_CLS_HW;
      err_d.ext = st_done ? AMER_EXT_GENERAL : AMER_EXT_POWERUP;
    end else if (cfg_err_q) begin
      err_d.cls = AMER_CLS_CFG;
      err_d.ext = cfg_code_q;
    end else begin
      err_d.cls = AMER_CLS_NONE;
      err_d.ext = AMER_EXT_GENERAL;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      err_q <= '0;
      led_q <= 1'b0;
    end else begin
      err_q <= err_d;
      led_q <= st_done & ~hw_fault_q;
    end
  end
  assign err_word_o = err_q;
  assign led_o = led_q;
  // The controller drops out of run mode on this level
  assign critical_o = (err_q.cls == AMER_CLS_HW) & st_done_q;

  // Per channel: range flags on each sample, output data with fault zeroing
  for (genvar g = 0; g < NCH; g++) begin : g_ch
    logic [1:0] rng;
    assign rng = cfg_q[2*g +: 2];
    assign over_now[g] = samples_i[g] > AMER_RANGE_HI[rng];
    assign under_now[g] = samples_i[g] < AMER_RANGE_LO[rng];
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        image_q[g] <= '0;
      end else if (sample_valid_i[g]) begin
        image_q[g] <= '{over: over_now[g], under: under_now[g], data: samples_i[g]};
      end
    end
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        dac_q[g] <= 16'h0000;
      end else if (wr_en && sel_dac && (ch_idx == 3'(g))) begin
        dac_q[g] <= 16'(amer_merge({16'h0000, dac_q[g]}, writedata, byteenable));
      end
    end
    // Range errors never touch the outputs; only a module fault or a self-test not yet passed does
    always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
        dac_out_q[g] <= 16'h0000;
      end else begin
        dac_out_q[g] <= hw_active ? 16'h0000 : dac_q[g];
      end
    end
    assign over_o[g] = image_q[g].over;
    assign under_o[g] = image_q[g].under;
  end
  assign dac_o = dac_out_q;

  // Interrupt sources and write-one-to-clear
  logic range_evt;
  assign range_evt = |(sample_valid_i & (over_now | under_now));
  assign irq_set[AMER_IRQ_DONE] = st_done & ~st_done_q;
  assign irq_set[AMER_IRQ_HW] = ~hw_fault_q & ((st_done & ~st_pass) | fault_f_q);
  assign irq_set[AMER_IRQ_CFG] = cfg_wr & ~cfg_ok;
  assign irq_set[AMER_IRQ_RANGE] = range_evt;
  assign irq_clr = (wr_en & sel_ist & byteenable[0]) ? writedata[AMER_NIRQ-1:0] : '0;

  // A set in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      irq_st_q <= '0;
      irq_msk_q <= AMER_MSK_RST;
    end else begin
      irq_st_q <= (irq_st_q & ~irq_clr) | irq_set;
      if (wr_en && sel_imsk && byteenable[0]) begin
        irq_msk_q <= writedata[AMER_NIRQ-1:0];
      end
    end
  end
  assign irq = |(irq_st_q & irq_msk_q);

  // Read mux; unmapped addresses read zero and writes there are dropped
  logic [31:0] rmux;
  logic [31:0] stat_word;
  assign stat_word = 32'({cfg_err_q, led_q, hw_fault_q, st_done});
  assign rmux = sel_err ? {16'h0000, err_q} :
                sel_stat ? stat_word :
                sel_cfg ? cfg_q :
                sel_ist ? 32'(irq_st_q) :
                sel_imsk ? 32'(irq_msk_q) :
                sel_img ? {14'h0000, image_q[ch_idx]} :
                sel_dac ? {16'h0000, dac_q[ch_idx]} : 32'h0000_0000;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && !ack_q) begin
      rdata_q <= rmux;
    end
  end
  assign readdata = rdata_q;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  sequence s_bad_cfg;
    cfg_wr && !cfg_ok;
  endsequence
  sequence s_cfg_kept;
    $stable(cfg_q) && cfg_err_q;
  endsequence
  sequence s_hw_seen;
    hw_fault_q ##1 (err_q.cls == AMER_CLS_HW);
  endsequence

  chk_dac_zero_fault: assert property (hw_active |=> dac_o == '0)
    else $error("outputs not zero during fault");
  chk_led_before_test: assert property (!st_done |=> !led_o)
    else $error("indicator on before self-test end");
  chk_led_healthy: assert property ((st_done && !hw_fault_q) [*2] |-> led_o)
    else $error("indicator off while healthy");
  chk_led_fault_off: assert property (hw_fault_q |=> !led_o)
    else $error("indicator on during fault");
  chk_hw_reported: assert property ($rose(fault_f_q) |=> s_hw_seen)
    else $error("pin fault not in error word");
  chk_over_flag: assert property (sample_valid_i[0] && over_now[0] |=> over_o[0])
    else $error("over-range flag missing");
  chk_range_nocrit: assert property (range_evt && !hw_active && !fault_f_q && !fault_s3_q
    |=> !hw_fault_q)
    else $error("range error became critical");
  chk_cfg_reject: assert property (s_bad_cfg |=> s_cfg_kept)
    else $error("invalid configuration accepted");
  chk_cfg_code: assert property ((s_bad_cfg ##1 !hw_active)
    |=> err_q == {4'h0, AMER_CLS_CFG, $past(bad_code, 2)})
    else $error("configuration code wrong");
  chk_ext_zero: assert property (err_q.cls == AMER_CLS_NONE |-> err_q.ext == 9'h000)
    else $error("extended field set with no error");
  chk_word_zero: assert property (err_q.cls == AMER_CLS_NONE |-> err_word_o == 16'h0000)
    else $error("error word not zero when clean");
  chk_hw_general: assert property (hw_fault_q && st_done
    |=> err_word_o == AMER_ERR_HW_GENERAL)
    else $error("hardware error code not general");
  chk_cfg_general: assert property ((s_bad_cfg ##0 bad_code == AMER_EXT_GENERAL
    ##1 !hw_active) |=> err_word_o == AMER_ERR_CFG_GENERAL)
    else $error("general configuration code wrong");
  chk_class_hw: assert property (!st_done |=> err_q.cls == AMER_CLS_HW)
    else $error("power-up class not hardware");
  chk_irq_set_wins: assert property (|irq_set |=> (irq_st_q & $past(irq_set)) == $past(irq_set))
    else $error("interrupt event lost");
  chk_bus_one_wait: assert property (req && waitrequest |=> !waitrequest)
    else $error("bus answer late");

  // Further reporting paths: interrupt events, accepted setups, word layout
  chk_under_flag: assert property (sample_valid_i[0] && under_now[0] |=> under_o[0])
    else $error("under-range flag missing");
  chk_range_event: assert property (range_evt |=> irq_st_q[AMER_IRQ_RANGE])
    else $error("range event not recorded");
  chk_hw_event: assert property ($rose(hw_fault_q) |-> irq_st_q[AMER_IRQ_HW])
    else $error("hardware fault event not recorded");
  chk_critical_hw: assert property (hw_fault_q && st_done_q |=> critical_o)
    else $error("critical level missing on hardware fault");
  chk_dac_follows: assert property (!hw_active |=> dac_o == $past(dac_q))
    else $error("outputs held while healthy");
  chk_cfg_accept: assert property (cfg_wr && cfg_ok
    |=> !cfg_err_q && cfg_q == $past(cfg_cand))
    else $error("valid configuration not taken");
  chk_cfg_event: assert property (s_bad_cfg |=> irq_st_q[AMER_IRQ_CFG])
    else $error("rejected configuration not recorded");
  chk_led_cfg_err: assert property (cfg_err_q && st_done && !hw_fault_q |=> led_o)
    else $error("indicator dark on configuration error");
  chk_class_cfg: assert property (cfg_err_q && !hw_active |=> err_q.cls == AMER_CLS_CFG)
    else $error("configuration class missing");
  chk_powerup_word: assert property (!st_done
    |=> err_word_o == {4'h0, AMER_CLS_HW, AMER_EXT_POWERUP})
    else $error("power-up word wrong");
  chk_dontcare_zero: assert property (err_word_o[15:12] == 4'h0)
    else $error("don't-care bits not zero");
endmodule : amer_core

// ### design/amer_pkg.sv
// Constants, types and helpers of the analog module error reporting block.
// Assumes one 200 MHz clock and an Avalon-MM master that owns the register bus.
// Behaviour
// - Any module fault forces every analog output channel to zero.
// - A power-up self-test sequence runs before normal operation begins.
// - Status indicator is steadily on when healthy, off on a module fault; a failed self-test lights it for one cycle before it goes off.
// - Diagnose module and channels; report hardware faults to the controller status.
// - Over-range and under-range flags per channel sit in the input image.
// - Channel range errors are non-critical; the module keeps operating.
// - Error word: bits 15-12 don't care, 11-9 class, 8-0 extended code.
// - Class codes: 000 none, 001 hardware, 010 configuration.
// - Extended field is zero whenever the class says no error.
// - Invalid configuration is rejected, flagged non-critical, previous one kept.
// - Extended field names the invalid configuration option beside the configuration class.
// - Hardware error without detail reads class 001, extended zero, X200.
// - Configuration error without detail reads class 010, extended zero, X400.
package amer_pkg;
  localparam int unsigned AMER_NCH = 4;
  localparam logic [2:0] AMER_CLS_NONE = 3'h0;
  localparam logic [2:0] AMER_CLS_HW = 3'h1;
  localparam logic [2:0] AMER_CLS_CFG = 3'h2;
  localparam logic [8:0] AMER_EXT_GENERAL = 9'h000;
  localparam logic [8:0] AMER_EXT_POWERUP = 9'h001;
  localparam logic [15:0] AMER_ERR_HW_GENERAL = 16'h0200;
  localparam logic [15:0] AMER_ERR_CFG_GENERAL = 16'h0400;
  // Register byte offsets
  localparam logic [7:0] AMER_OFS_ERR = 8'h00;
  localparam logic [7:0] AMER_OFS_STAT = 8'h04;
  localparam logic [7:0] AMER_OFS_CFG = 8'h08;
  localparam logic [7:0] AMER_OFS_IRQ_ST = 8'h0c;
  localparam logic [7:0] AMER_OFS_IRQ_MSK = 8'h10;
  localparam logic [7:0] AMER_OFS_IMG = 8'h20;
  localparam logic [7:0] AMER_OFS_DAC = 8'h40;
  localparam logic [31:0] AMER_CFG_RST = 32'h0000_0000;
  localparam logic [3:0] AMER_MSK_RST = 4'h0;
  // Interrupt and status bit positions
  localparam int unsigned AMER_NIRQ = 4;
  localparam int unsigned AMER_IRQ_DONE = 0;
  localparam int unsigned AMER_IRQ_HW = 1;
  localparam int unsigned AMER_IRQ_CFG = 2;
  localparam int unsigned AMER_IRQ_RANGE = 3;
  localparam int unsigned AMER_ST_DONE = 0;
  localparam int unsigned AMER_ST_FAULT = 1;
  localparam int unsigned AMER_ST_LED = 2;
  localparam int unsigned AMER_ST_CFGERR = 3;
  // Range codes above the maximum are unsupported
  localparam logic [1:0] AMER_RANGE_MAX = 2'h2;
  localparam logic [3:0][15:0] AMER_RANGE_HI = {16'hffff, 16'hfeff, 16'hfff0, 16'h7fff};
  localparam logic [3:0][15:0] AMER_RANGE_LO = {16'h0000, 16'h0800, 16'h0400, 16'h0000};
  // Self-test timing
  localparam int unsigned AMER_ST_STEPS = 8;
  localparam int unsigned AMER_CLK_PS = 5000;
  localparam int unsigned AMER_ST_SETTLE_NS = 100;
  localparam int unsigned AMER_ST_SETTLE_CYC = (AMER_ST_SETTLE_NS * 1000 + AMER_CLK_PS - 1)
                                               / AMER_CLK_PS;
  typedef struct packed {
    logic [3:0] dont_care;
    logic [2:0] cls;
    logic [8:0] ext;
  } amer_err_t;
  typedef struct packed {
    logic over;
    logic under;
    logic [15:0] data;
  } amer_image_t;
  // Byte-lane merge for partial writes
  function automatic logic [31:0] amer_merge(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction : amer_merge
endpackage : amer_pkg

// ### design/amer_selftest.sv
// Power-up self-test sequencer: walks the test steps, waits settle, checks result.
// Assumes test_ok comes from logic on the same clock and is valid after settle.
module amer_selftest
  import amer_pkg::*;
#(
  parameter int unsigned STEPS = AMER_ST_STEPS,
  parameter int unsigned SETTLE = AMER_ST_SETTLE_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic test_ok,
  output logic [7:0] test_sel,
  output logic done,
  output logic pass
);
  typedef enum logic [1:0] {
    AMER_S_SETTLE = 2'b00,
    AMER_S_CHECK = 2'b01,
    AMER_S_PASS = 2'b10,
    AMER_S_FAIL = 2'b11
  } amer_st_t;
  amer_st_t st_q;
  logic [15:0] cnt_q;
  logic [7:0] step_q;
  // Sequence: settle, check, next step; a single failed check ends it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= AMER_S_SETTLE;
      cnt_q <= 16'h0000;
      step_q <= 8'h00;
    end else begin
      unique case (st_q)
        AMER_S_SETTLE: begin
          cnt_q <= cnt_q + 16'h0001;
          if (cnt_q == 16'(SETTLE - 1)) begin
            st_q <= AMER_S_CHECK;
          end
        end
        AMER_S_CHECK: begin
          cnt_q <= 16'h0000;
          if (!test_ok) begin
            st_q <= AMER_S_FAIL;
          end else if (step_q == 8'(STEPS - 1)) begin
            st_q <= AMER_S_PASS;
          end else begin
            step_q <= step_q + 8'h01;
            st_q <= AMER_S_SETTLE;
          end
        end
        AMER_S_PASS: st_q <= AMER_S_PASS;
        AMER_S_FAIL: st_q <= AMER_S_FAIL;
      endcase
    end
  end
  assign test_sel = step_q;
  assign done = st_q[1];
  assign pass = (st_q == AMER_S_PASS);
  // Terminal states are final until the next power-up
  chk_st_terminal_hold: assert property (@(posedge clk) disable iff (!resetn)
    done |=> done && $stable(pass)) else $error("self-test result changed");
endmodule : amer_selftest

// ### sim/amer_host_model.sv
// Behavioural model of the controller that reads the module error word.
// Assumes the word and the critical flag come from registers on clk.
module amer_host_model
  import amer_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic [15:0] err_word,
  input wire logic critical,
  output logic run_mode_q,
  output logic [8:0] ext_seen_q
);
  timeunit 1ns;
  timeprecision 1ps;
  amer_err_t word;

  // Struct view of the word so class and detail are picked by field
  assign word = amer_err_t'(err_word);

  // Run mode is left for good on a critical error; only reset restores it
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      run_mode_q <= 1'b1;
      ext_seen_q <= 9'h000;
    end else begin
      if (critical) begin
        run_mode_q <= 1'b0;
      end
      // Detail is meaningless without a class, so it is not taken then
      if (word.cls != AMER_CLS_NONE) begin
        ext_seen_q <= word.ext;
      end
    end
  end
endmodule : amer_host_model

// ### sim/amer_core_test.sv
// Self-checking bench of the error reporting core with a controller model.
// Assumes a short self-test (two steps, two settle cycles) for run time.
module amer_core_test
  import amer_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, resetn, read, write, test_ok_i, hw_fault_pin;
  logic [7:0] address;
  logic [31:0] writedata, readdata, rd;
  logic [3:0] byteenable, sample_valid_i, over_o, under_o;
  logic waitrequest, critical_o, led_o, irq, run_mode_q;
  logic [3:0][15:0] samples_i, dac_o;
  logic [15:0] err_word_o;
  logic [8:0] ext_seen_q;
  logic [7:0] test_sel_o;
  int fails, samples_checked;

  amer_core #(.NCH(4), .ST_STEPS(2), .ST_SETTLE(2)) u_amer_core (
    .clk(clk), .resetn(resetn), .address(address), .read(read), .write(write),
    .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .samples_i(samples_i), .sample_valid_i(sample_valid_i),
    .test_ok_i(test_ok_i), .test_sel_o(test_sel_o), .hw_fault_pin(hw_fault_pin),
    .dac_o(dac_o), .over_o(over_o), .under_o(under_o), .err_word_o(err_word_o),
    .critical_o(critical_o), .led_o(led_o), .irq(irq));

  amer_host_model u_amer_host_model (
    .clk(clk), .resetn(resetn), .err_word(err_word_o), .critical(critical_o),
    .run_mode_q(run_mode_q), .ext_seen_q(ext_seen_q));

  // 200 MHz clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic stop_test();
    if (fails == 0 && samples_checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : stop_test

  // Four-state compare, so an unknown never matches
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  // One Avalon access; held until the edge that sees waitrequest low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= ~wr;
    do begin
      @(posedge clk);
      n++;
    end while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    write <= 1'b0;
    read <= 1'b0;
    if (n >= 50) begin
      fails++;
      stop_test();
    end
  endtask : bus

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(rd, exp);
  endtask : rd_chk

  task automatic sample(input logic [15:0] v);
    @(posedge clk);
    samples_i[0] <= v;
    sample_valid_i <= 4'h1;
    @(posedge clk);
    sample_valid_i <= 4'h0;
    cyc(2);
  endtask : sample

  // Poll the status word until the self-test ends; a hang counts and ends the run
  task automatic wait_done();
    int n;
    n = 0;
    do begin
      bus(1'b0, AMER_OFS_STAT, 32'h0000_0000);
      n++;
    end while (rd[AMER_ST_DONE] !== 1'b1 && n < 40);
    if (rd[AMER_ST_DONE] !== 1'b1) begin
      fails++;
      stop_test();
    end
  endtask : wait_done

  // Power-up word, then self-test completion gives a clean word and a lit indicator
  task automatic t_selftest();
    chk({16'h0, err_word_o}, 32'h0000_0201);
    chk({31'h0, led_o}, 32'h0000_0000);
    chk({16'h0, dac_o[0]}, 32'h0000_0000);
    rd_chk(AMER_OFS_IRQ_MSK, 32'h0000_0000);
    wait_done();
    cyc(3);
    chk({24'h0, test_sel_o}, 32'h0000_0001);
    chk({16'h0, err_word_o}, 32'h0000_0000);
    chk({31'h0, led_o}, 32'h0000_0001);
    chk({31'h0, irq}, 32'h0000_0000);
    bus(1'b1, AMER_OFS_IRQ_MSK, 32'h0000_0001);
    cyc(2);
    chk({31'h0, irq}, 32'h0000_0001);
    bus(1'b1, AMER_OFS_IRQ_ST, 32'h0000_0001);
    cyc(2);
    chk({31'h0, irq}, 32'h0000_0000);
  endtask : t_selftest

  // Range flags in the image; the module keeps running meanwhile
  task automatic t_range();
    bus(1'b1, AMER_OFS_CFG, 32'h0000_0001);
    bus(1'b1, AMER_OFS_DAC, 32'h0000_1234);
    cyc(2);
    chk({16'h0, dac_o[0]}, 32'h0000_1234);
    sample(16'h0100);
    chk({28'h0, under_o}, 32'h0000_0001);
    rd_chk(AMER_OFS_IMG, 32'h0001_0100);
    sample(16'hfff8);
    chk({28'h0, over_o}, 32'h0000_0001);
    rd_chk(AMER_OFS_IMG, 32'h0002_fff8);
    chk({31'h0, led_o}, 32'h0000_0001);
    chk({16'h0, err_word_o}, 32'h0000_0000);
    sample(16'h1000);
    chk({24'h0, over_o, under_o}, 32'h0000_0000);
  endtask : t_range

  // Rejected settings leave the old one in place and name the bad option
  task automatic t_config();
    bus(1'b1, AMER_OFS_CFG, 32'h0000_0030);
    cyc(3);
    chk({16'h0, err_word_o}, 32'h0000_0403);
    chk({23'h0, ext_seen_q}, 32'h0000_0003);
    rd_chk(AMER_OFS_CFG, 32'h0000_0001);
    chk({31'h0, led_o}, 32'h0000_0001);
    chk({16'h0, dac_o[0]}, 32'h0000_1234);
    bus(1'b1, AMER_OFS_CFG, 32'h0000_0100);
    cyc(3);
    chk({16'h0, err_word_o}, 32'h0000_0400);
    bus(1'b1, AMER_OFS_CFG, 32'h0000_0001);
    cyc(3);
    chk({16'h0, err_word_o}, 32'h0000_0000);
    bus(1'b1, 8'h84, 32'h0000_ffff);
    rd_chk(8'h84, 32'h0000_0000);
  endtask : t_config

  // A hardware fault zeroes outputs, darkens the indicator, stops the controller
  task automatic t_hwfault();
    int n;
    @(posedge clk);
    hw_fault_pin <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (led_o !== 1'b0 && n < 40);
    if (led_o !== 1'b0) begin
      fails++;
      stop_test();
    end
    cyc(3);
    chk({31'h0, led_o}, 32'h0000_0000);
    chk({16'h0, dac_o[0]}, 32'h0000_0000);
    chk({16'h0, err_word_o}, 32'h0000_0200);
    chk({31'h0, critical_o}, 32'h0000_0001);
    chk({31'h0, run_mode_q}, 32'h0000_0000);
    rd_chk(AMER_OFS_ERR, 32'h0000_0200);
    rd_chk(AMER_OFS_IRQ_ST, 32'h0000_000e);
  endtask : t_hwfault

  // Mid-run reset with a failing test step: hardware class, outputs held at zero
  task automatic t_stfail();
    @(posedge clk);
    resetn <= 1'b0;
    test_ok_i <= 1'b0;
    hw_fault_pin <= 1'b0;
    cyc(2);
    chk({16'h0, err_word_o}, 32'h0000_0000);
    resetn <= 1'b1;
    cyc(2);
    chk({16'h0, err_word_o}, 32'h0000_0201);
    chk({31'h0, run_mode_q}, 32'h0000_0001);
    bus(1'b1, AMER_OFS_DAC, 32'h0000_1234);
    wait_done();
    cyc(3);
    chk({16'h0, err_word_o}, 32'h0000_0200);
    chk({31'h0, led_o}, 32'h0000_0000);
    chk({16'h0, dac_o[0]}, 32'h0000_0000);
    chk({24'h0, test_sel_o}, 32'h0000_0000);
    chk({31'h0, run_mode_q}, 32'h0000_0000);
    rd_chk(AMER_OFS_STAT, 32'h0000_0003);
    rd_chk(AMER_OFS_IRQ_ST, 32'h0000_0003);
  endtask : t_stfail

  initial begin
    fails = 0;
    samples_checked = 0;
    resetn = 1'b0;
    read = 1'b0;
    write = 1'b0;
    address = 8'h00;
    writedata = 32'h0000_0000;
    byteenable = 4'hf;
    samples_i = '0;
    sample_valid_i = 4'h0;
    test_ok_i = 1'b1;
    hw_fault_pin = 1'b0;
    cyc(8);
    resetn <= 1'b1;
    cyc(2);
    t_selftest();
    t_range();
    t_config();
    t_hwfault();
    t_stfail();
    stop_test();
  end
endmodule : amer_core_test
